// *** hw/iox_seg_xlate.sv ***
// Purpose: Translation path for interface-type segments
// Assumes: One access request at a time; bus_ack from the memory controller
// Notes: Descriptor writes wait while a bus transfer is open
`timescale 1ns/10ps
module iox_seg_xlate (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic desc_wr_en,
    input wire logic [31:0] desc_wr_data,
    output logic desc_wr_ready,
    output logic [31:0] segment_descriptor,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [31:0] req_logical_address,
    input wire iox_pkg::iox_kind_e req_kind,
    input wire logic privilege_state_bit,
    input wire logic data_translation_enable,
    input wire logic bat_hit,
    output logic std_valid,
    output logic std_bat_use,
    output logic std_page_walk,
    output logic noop_done,
    output logic undef_done,
    output logic fault_pulse,
    output logic [31:0] data_fault_status,
    input wire logic fault_clear,
    output logic bus_valid,
    output logic [31:0] bus_addr,
    output logic bus_addr_only,
    output logic bus_pkt1,
    output logic [2:0] storage_attribute_bits,
    input wire logic bus_ack,
    output logic io_done
);
    import iox_pkg::*;

    typedef struct packed {
        iox_state_e st;
        logic [31:0] desc;
        logic [31:0] pkt1;
        logic bus_valid;
        logic [31:0] bus_addr;
        logic bus_addr_only;
        logic bus_pkt1;
        logic [2:0] attr;
        logic std;
        logic bat_use;
        logic page_walk;
        logic noop;
        logic undef;
        logic fault;
        logic [31:0] status;
        logic done;
    } iox_regs_s;

    iox_regs_s r_q;
    iox_regs_s r_d;

    function automatic logic is_mem_forced(input logic [31:0] d);
        return d[IOX_T_BIT] && (d[IOX_BUS_UNIT_IDENTIFIER_HI:IOX_BUS_UNIT_IDENTIFIER_LO] == IOX_BUS_UNIT_IDENTIFIER_MEM);
    endfunction : is_mem_forced

    function automatic logic [31:0] tail_addr(input logic [31:0] d, input logic [31:0] la);
        return {d[IOX_TAIL_HI:0], la[IOX_LA_HI:0]};
    endfunction : tail_addr

    logic fire;
    logic seg_t;
    logic mem_forced;
    logic key_sel;

    assign req_ready = (r_q.st == IOX_S_IDLE);
    assign desc_wr_ready = (r_q.st == IOX_S_IDLE);
    assign fire = req_valid && req_ready;
    assign seg_t = r_q.desc[IOX_T_BIT];
    assign mem_forced = is_mem_forced(r_q.desc);
    // Key select only; no protection check here, controller owns it
    assign key_sel = privilege_state_bit ? r_q.desc[IOX_KU_BIT] : r_q.desc[IOX_KS_BIT];

    always_comb begin
        r_d = r_q;
        r_d.std = 1'b0;
        r_d.noop = 1'b0;
        r_d.undef = 1'b0;
        r_d.fault = 1'b0;
        r_d.done = 1'b0;
        if (desc_wr_en && desc_wr_ready) begin
            r_d.desc = desc_wr_data;
        end
        // Clear loses to a fault raised in the same cycle
        if (fault_clear) begin
            r_d.status = IOX_FAULT_RST;
        end
        case (r_q.st)
            IOX_S_IDLE: begin
                if (fire) begin
                    // Stale flags of an earlier normal access must not leak into this one
                    r_d.bat_use = 1'b0;
                    r_d.page_walk = 1'b0;
                    if (req_kind == IOX_K_EXTCTL && (seg_t || !data_translation_enable)) begin
                        r_d.undef = 1'b1;
                    end else if (!seg_t) begin
                        r_d.std = 1'b1;
                        r_d.bat_use = bat_hit && data_translation_enable;
                        r_d.page_walk = !bat_hit && data_translation_enable;
                    end else if (req_kind == IOX_K_RESERVE) begin
                        r_d.fault = 1'b1;
                        r_d.status[IOX_FAULT_BIT] = 1'b1;
                    end else if (req_kind == IOX_K_CACHEOP) begin
                        r_d.noop = 1'b1;
                    end else if (mem_forced) begin
                        r_d.st = IOX_S_MEM;
                        r_d.bus_valid = 1'b1;
                        r_d.bus_addr_only = 1'b0;
                        r_d.bus_pkt1 = 1'b0;
                        r_d.bus_addr = tail_addr(r_q.desc, req_logical_address);
                        r_d.attr = IOX_ATTR_MEM;
                    end else begin
                        // Block hit and page tables are not consulted
                        r_d.bat_use = 1'b0;
                        r_d.page_walk = 1'b0;
                        r_d.st = IOX_S_PKT0;
                        r_d.bus_valid = 1'b1;
                        r_d.bus_addr_only = 1'b1;
                        r_d.bus_pkt1 = 1'b0;
                        r_d.bus_addr = {2'b00, key_sel, r_q.desc[IOX_BUS_UNIT_IDENTIFIER_HI:0]};
                        r_d.pkt1 = tail_addr(r_q.desc, req_logical_address);
                        r_d.attr = IOX_ATTR_IO;
                    end
                end
            end
            IOX_S_PKT0: begin
                if (bus_ack) begin
                    r_d.st = IOX_S_PKT1;
                    r_d.bus_pkt1 = 1'b1;
                    r_d.bus_addr = r_q.pkt1;
                end
            end
            IOX_S_PKT1, IOX_S_MEM: begin
                if (bus_ack) begin
                    r_d.st = IOX_S_IDLE;
                    r_d.bus_valid = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            default: begin
                r_d.st = IOX_S_IDLE;
            end
        endcase
        if (r_d.fault) begin
            r_d.status[IOX_FAULT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r_q <= '{st: IOX_S_IDLE, desc: IOX_DESC_RST, status: IOX_FAULT_RST,
                     attr: 3'h0, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign segment_descriptor = r_q.desc;
    assign std_valid = r_q.std;
    assign std_bat_use = r_q.bat_use;
    assign std_page_walk = r_q.page_walk;
    assign noop_done = r_q.noop;
    assign undef_done = r_q.undef;
    assign fault_pulse = r_q.fault;
    assign data_fault_status = r_q.status;
    assign bus_valid = r_q.bus_valid;
    assign bus_addr = r_q.bus_addr;
    assign bus_addr_only = r_q.bus_addr_only;
    assign bus_pkt1 = r_q.bus_pkt1;
    assign storage_attribute_bits = r_q.attr;
    assign io_done = r_q.done;

    logic io_fire;
    assign io_fire = fire && seg_t && !mem_forced && req_kind != IOX_K_RESERVE
        && req_kind != IOX_K_CACHEOP && req_kind != IOX_K_EXTCTL;

    chk_t_no_bat: assert property (@(posedge clk_sys) disable iff (rst)
        fire && seg_t |=> !std_valid && !std_bat_use)
        else $error("Type segment used block translation");

    chk_no_page_walk: assert property (@(posedge clk_sys) disable iff (rst)
        io_fire |=> !std_page_walk throughout (bus_valid [*2]))
        else $error("Page walk during interface access");

    chk_pkt_order: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && bus_addr_only && !bus_pkt1 && bus_ack |=> bus_valid && bus_pkt1 && bus_addr_only)
        else $error("Packet 1 did not follow packet 0");

    chk_key_super: assert property (@(posedge clk_sys) disable iff (rst)
        io_fire && !privilege_state_bit |=> bus_addr[29] == $past(segment_descriptor[30]))
        else $error("Supervisor key not sent");

    chk_key_user: assert property (@(posedge clk_sys) disable iff (rst)
        io_fire && privilege_state_bit |=> bus_addr[29] == $past(segment_descriptor[29]))
        else $error("User key not sent");

    chk_pkt0_body: assert property (@(posedge clk_sys) disable iff (rst)
        io_fire |=> bus_addr[28:0] == $past(segment_descriptor[28:0]) && !bus_pkt1)
        else $error("Packet 0 body wrong");

    chk_pkt1_body: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && bus_pkt1 |-> bus_addr[31:28] == segment_descriptor[3:0])
        else $error("Packet 1 descriptor tail wrong");

    chk_io_attr: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && bus_addr_only |-> storage_attribute_bits == 3'h2)
        else $error("Interface attributes not 010");

    chk_mf_access: assert property (@(posedge clk_sys) disable iff (rst)
        fire && mem_forced && req_kind == IOX_K_LOAD
        |=> bus_valid && bus_addr == tail_addr($past(segment_descriptor), $past(req_logical_address)))
        else $error("Memory-forced address wrong");

    chk_mf_attr: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && !bus_addr_only |-> storage_attribute_bits == 3'h3)
        else $error("Memory-forced attributes not 011");

    chk_mf_no_pkt: assert property (@(posedge clk_sys) disable iff (rst)
        fire && mem_forced && req_kind == IOX_K_STORE |=> !bus_addr_only)
        else $error("Memory-forced access sent packets");

    chk_reserve_exc: assert property (@(posedge clk_sys) disable iff (rst)
        fire && seg_t && req_kind == IOX_K_RESERVE |=> fault_pulse && data_fault_status[26])
        else $error("Fault not raised for reserve op");

    chk_cache_noop: assert property (@(posedge clk_sys) disable iff (rst)
        fire && seg_t && req_kind == IOX_K_CACHEOP |=> noop_done && !bus_valid)
        else $error("Cache op on type segment not a no-op");

    // Controller handshake
    chk_bus_hold: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && !bus_ack |=> bus_valid && $stable(bus_addr) && $stable(bus_pkt1))
        else $error("Bus cycle changed before acknowledge");

    chk_pkt0_first: assert property (@(posedge clk_sys) disable iff (rst)
        io_fire |=> bus_valid && bus_addr_only && !bus_pkt1
            && storage_attribute_bits == IOX_ATTR_IO)
        else $error("Interface access did not open with packet 0");

    chk_pkt1_done: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && bus_pkt1 && bus_ack |=> !bus_valid && io_done)
        else $error("Access not closed after packet 1");

    chk_mf_done: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && !bus_addr_only && bus_ack |=> !bus_valid && io_done)
        else $error("Memory-forced access not closed after one cycle");

    chk_done_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        io_done |=> !io_done)
        else $error("Done held longer than one cycle");

    chk_pkt1_attr: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && bus_pkt1 |-> bus_addr_only && storage_attribute_bits == IOX_ATTR_IO)
        else $error("Packet 1 attributes wrong");

    chk_mf_single: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid && !bus_addr_only |-> !bus_pkt1)
        else $error("Memory-forced access marked as packet 1");

    chk_pkt0_high: assert property (@(posedge clk_sys) disable iff (rst)
        io_fire |=> bus_addr[31:30] == 2'b00)
        else $error("Packet 0 upper bits not zero");

    // Request outcome
    chk_busy_ready: assert property (@(posedge clk_sys) disable iff (rst)
        bus_valid |-> !req_ready && !desc_wr_ready)
        else $error("Ready while a bus cycle is open");

    chk_done_ready: assert property (@(posedge clk_sys) disable iff (rst)
        io_done |-> req_ready && !bus_valid)
        else $error("Not idle when access completes");

    chk_outcome_one: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot0({std_valid, noop_done, undef_done, fault_pulse, io_done}))
        else $error("Two outcomes in one cycle");

    chk_ext_undef: assert property (@(posedge clk_sys) disable iff (rst)
        fire && req_kind == IOX_K_EXTCTL && (seg_t || !data_translation_enable)
        |=> undef_done && !bus_valid && !std_valid)
        else $error("External control op not dropped");

    chk_std_flags: assert property (@(posedge clk_sys) disable iff (rst)
        fire && !seg_t && req_kind != IOX_K_EXTCTL |=> std_valid
            && std_bat_use == $past(bat_hit && data_translation_enable)
            && std_page_walk == $past(!bat_hit && data_translation_enable))
        else $error("Normal translation flags wrong");

    chk_std_no_bus: assert property (@(posedge clk_sys) disable iff (rst)
        std_valid |-> !bus_valid)
        else $error("Normal access opened an interface cycle");

    chk_t_no_walk: assert property (@(posedge clk_sys) disable iff (rst)
        fire && seg_t |=> !std_page_walk)
        else $error("Page walk flagged for type segment");

    chk_prot_absent: assert property (@(posedge clk_sys) disable iff (rst)
        fire && seg_t && req_kind != IOX_K_RESERVE |=> !fault_pulse)
        else $error("Protection fault on type segment");

    chk_mf_plain: assert property (@(posedge clk_sys) disable iff (rst)
        fire && mem_forced && req_kind inside {IOX_K_LOAD, IOX_K_STORE, IOX_K_FETCH}
        |=> bus_valid && !bus_addr_only && storage_attribute_bits == IOX_ATTR_MEM)
        else $error("Memory-forced access not a plain access");

    chk_noop_idle: assert property (@(posedge clk_sys) disable iff (rst)
        noop_done |-> req_ready && !std_valid && !bus_valid)
        else $error("Cache op left side effects");

    chk_reserve_nobus: assert property (@(posedge clk_sys) disable iff (rst)
        fire && seg_t && req_kind == IOX_K_RESERVE |=> !bus_valid && !io_done)
        else $error("Reserve op reached the bus");

    // Descriptor and fault status
    chk_desc_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !desc_wr_ready |=> $stable(segment_descriptor))
        else $error("Descriptor changed while busy");

    chk_desc_write: assert property (@(posedge clk_sys) disable iff (rst)
        desc_wr_en && desc_wr_ready |=> segment_descriptor == $past(desc_wr_data))
        else $error("Descriptor write lost");

    chk_fault_flag: assert property (@(posedge clk_sys) disable iff (rst)
        fault_pulse |-> data_fault_status[IOX_FAULT_BIT])
        else $error("Fault raised without status bit");

    chk_fault_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        data_fault_status[IOX_FAULT_BIT] && !fault_clear |=> data_fault_status[IOX_FAULT_BIT])
        else $error("Fault status bit dropped without clear");

    // A new fault in the clearing cycle keeps the bit
    chk_fault_clear: assert property (@(posedge clk_sys) disable iff (rst)
        fault_clear && !(fire && seg_t && req_kind == IOX_K_RESERVE)
        |=> !data_fault_status[IOX_FAULT_BIT])
        else $error("Fault status not cleared");

    cov_io_pair: cover property (@(posedge clk_sys) disable iff (rst)
        io_fire ##[2:9] (bus_valid && bus_pkt1) ##[1:9] io_done);
    cov_mem_forced: cover property (@(posedge clk_sys) disable iff (rst)
        fire && mem_forced ##[1:8] io_done);
    cov_fault: cover property (@(posedge clk_sys) disable iff (rst) fault_pulse);
    cov_undef_ext: cover property (@(posedge clk_sys) disable iff (rst) undef_done);
    cov_cache_noop: cover property (@(posedge clk_sys) disable iff (rst) noop_done);
endmodule : iox_seg_xlate

// *** hw/iox_pkg.sv ***
// Purpose: Constants and types for the I/O segment translation path
// Assumes: Descriptor and address bits numbered with bit 0 as the MSB
// Notes: Big-endian bit n maps to vector index 31-n
// Behaviour
// - A segment with the type flag set uses interface translation and ignores any block hit.
// - Interface translation performs no page table lookup or reload.
// - Each interface access goes out as two address-only cycles, packet 0 then packet 1.
// - In supervisor state packet 0 carries the supervisor key and ignores the user key.
// - In user state packet 0 carries the user key and ignores the supervisor key.
// - Packet 0 also carries descriptor bits 3 to 31, bus unit id then controller data.
// - Packet 1 carries descriptor bits 28 to 31 then logical address bits 4 to 31.
// - Interface accesses force the storage attribute bits to 010.
// - Each bus transaction of an instruction is translated on its own.
// - No page protection is applied to interface segments; the controller enforces it.
// - Type flag with bus unit id 07f gives a plain memory access at the packet 1 address.
// - A memory-forced access uses storage attribute bits 011.
// - Reserve, conditional store and string compare on such a segment raise a fault with bit 5.
// - External control word ops on such a segment or with translation off are undefined.
// - Cache block ops on such a segment complete as no-ops with no bus effect.
// - The descriptor holds type, supervisor key, user key, bus unit id and controller data.
package iox_pkg;
    localparam int IOX_AW = 32;
    // Descriptor field positions
    localparam int IOX_T_BIT = 31;
    localparam int IOX_KS_BIT = 30;
    localparam int IOX_KU_BIT = 29;
    localparam int IOX_BUS_UNIT_IDENTIFIER_HI = 28;
    localparam int IOX_BUS_UNIT_IDENTIFIER_LO = 20;
    localparam int IOX_TAIL_HI = 3;
    localparam int IOX_LA_HI = 27;
    localparam logic [8:0] IOX_BUS_UNIT_IDENTIFIER_MEM = 9'h07f;
    // Storage attribute patterns
    localparam logic [2:0] IOX_ATTR_IO = 3'h2;
    localparam logic [2:0] IOX_ATTR_MEM = 3'h3;
    // Data fault status bit 5
    localparam int IOX_FAULT_BIT = 26;
    // Reset values
    localparam logic [31:0] IOX_DESC_RST = 32'h0000_0000;
    localparam logic [31:0] IOX_FAULT_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        IOX_K_LOAD = 3'b000,
        IOX_K_STORE = 3'b001,
        IOX_K_RESERVE = 3'b010,
        IOX_K_EXTCTL = 3'b011,
        IOX_K_CACHEOP = 3'b100,
        IOX_K_FETCH = 3'b101
    } iox_kind_e;

    typedef enum logic [1:0] {
        IOX_S_IDLE = 2'b00,
        IOX_S_PKT0 = 2'b01,
        IOX_S_PKT1 = 2'b10,
        IOX_S_MEM = 2'b11
    } iox_state_e;
endpackage : iox_pkg

// *** sim/iox_mem_ctl_model.sv ***
// Purpose: Memory controller stand-in that accepts address cycles
// Assumes: One ack per offered cycle, wait_cycles + 1 cycles after the cycle is offered
// Notes: Grants every packet; key checking is left to real controllers
`timescale 1ns/10ps
module iox_mem_ctl_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_valid,
    input wire logic [3:0] wait_cycles,
    output logic bus_ack
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk_sys) begin
        // Ack drops after one cycle so no single address cycle is acked twice
        if (rst || !bus_valid || bus_ack) begin
            cnt_q <= 4'h0;
            bus_ack <= 1'b0;
        end else if (cnt_q >= wait_cycles) begin
            bus_ack <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : iox_mem_ctl_model

// *** sim/io_segment_translation_tb.sv ***
// Purpose: Self-checking bench for the I/O segment translation path
// Assumes: Controller model acks each address cycle after a random wait
// Notes: Expected outcomes come from an integer reference model
`timescale 1ns/10ps
module io_segment_translation_tb;
    import iox_pkg::*;
    logic clk_sys = 0, rst = 1, desc_wr_en = 0, req_valid = 0, fault_clear = 0;
    logic privilege_state_bit = 0, data_translation_enable = 1, bat_hit = 0;
    logic [31:0] desc_wr_data = '0, req_logical_address = '0;
    iox_kind_e req_kind = IOX_K_LOAD;
    logic [3:0] wait_cycles = '0;
    logic desc_wr_ready, req_ready, std_valid, std_bat_use, std_page_walk, noop_done;
    logic undef_done, fault_pulse, bus_valid, bus_addr_only, bus_pkt1, bus_ack, io_done;
    logic [31:0] segment_descriptor, data_fault_status, bus_addr;
    logic [2:0] storage_attribute_bits;
    int err_count = 0, comparisons = 0, code;
    logic [15:0] rnd = 16'h96b2;
    logic [36:0] seen[$];

    iox_seg_xlate uut (
        .clk_sys, .rst, .desc_wr_en, .desc_wr_data, .desc_wr_ready, .segment_descriptor,
        .req_valid, .req_ready, .req_logical_address, .req_kind, .privilege_state_bit,
        .data_translation_enable, .bat_hit, .std_valid, .std_bat_use, .std_page_walk,
        .noop_done, .undef_done, .fault_pulse, .data_fault_status, .fault_clear,
        .bus_valid, .bus_addr, .bus_addr_only, .bus_pkt1, .storage_attribute_bits,
        .bus_ack, .io_done
    );
    iox_mem_ctl_model ctl (.clk_sys, .rst, .bus_valid, .wait_cycles, .bus_ack);

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task results;
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    task chk(input string nm, input logic [36:0] exp, input logic [36:0] got);
        comparisons++;
        if (exp !== got) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task step;
        @(posedge clk_sys);
        #1;
    endtask : step

    task guard(input int n);
        if (n > 200) begin
            err_count++;
            results;
        end
    endtask : guard

    task wr_desc(input logic [31:0] d);
        int n;
        n = 0;
        desc_wr_en = 1;
        desc_wr_data = d;
        while (desc_wr_ready !== 1'b1) begin
            step;
            guard(++n);
        end
        step;
        desc_wr_en = 0;
        chk("descriptor", d, segment_descriptor);
    endtask : wr_desc

    // Collects every accepted address cycle until the access reports its outcome
    task run_req;
        int n;
        n = 0;
        req_valid = 1;
        while (req_ready !== 1'b1) begin
            step;
            guard(++n);
        end
        step;
        req_valid = 0;
        seen.delete();
        code = 0;
        while (code == 0) begin
            if (bus_valid === 1'b1 && bus_ack === 1'b1)
                seen.push_back({bus_addr_only, bus_pkt1, storage_attribute_bits, bus_addr});
            code = undef_done ? 1 : std_valid ? 2 : fault_pulse ? 3 : noop_done ? 4 : io_done ? 5 : 0;
            if (code == 0) step;
            guard(++n);
        end
    endtask : run_req

    initial begin
        logic [31:0] d, la;
        logic [36:0] e[$];
        int ek, m;
        repeat (20) @(posedge clk_sys);
        #1 rst = 0;
        chk("reset", {1'b1, 32'h0}, {req_ready, segment_descriptor});
        for (int i = 0; i < 72; i++) begin
            m = (i / 6) % 3;
            rnd = lfsr(rnd);
            d = {rnd, lfsr(rnd)};
            rnd = lfsr(lfsr(rnd));
            la = {lfsr(rnd), rnd};
            d[31] = m != 0;
            if (m == 1) d[28] = 1'b1;
            if (m == 2) d[28:20] = 9'h07f;
            wr_desc(d);
            req_kind = iox_kind_e'(3'(i % 6));
            req_logical_address = la;
            privilege_state_bit = rnd[0];
            data_translation_enable = rnd[1] | rnd[2];
            bat_hit = rnd[3];
            wait_cycles = {1'b0, rnd[6:4]};
            run_req;
            ek = (req_kind == IOX_K_EXTCTL && (d[31] || !data_translation_enable)) ? 1 :
                !d[31] ? 2 : req_kind == IOX_K_RESERVE ? 3 : req_kind == IOX_K_CACHEOP ? 4 : 5;
            e.delete();
            if (ek == 5 && m == 2) e.push_back({2'b00, 3'h3, d[3:0], la[27:0]});
            if (ek == 5 && m == 1) begin
                e.push_back({2'b10, 3'h2, 2'b00, d[30 - privilege_state_bit], d[28:0]});
                e.push_back({2'b11, 3'h2, d[3:0], la[27:0]});
            end
            chk("outcome", ek, code);
            if (ek == 2)
                chk("std flags", {bat_hit & data_translation_enable,
                    !bat_hit & data_translation_enable}, {std_bat_use, std_page_walk});
            if (d[31])
                chk("type flags", 2'b00, {std_bat_use, std_page_walk});
            if (ek == 3) begin
                chk("fault bit", 1, data_fault_status[26]);
                fault_clear = 1;
                step;
                fault_clear = 0;
                chk("fault clear", 0, data_fault_status[26]);
            end
            chk("cycles", e.size(), seen.size());
            for (int k = 0; k < e.size() && k < seen.size(); k++)
                chk("packet", e[k], seen[k]);
        end
        results;
    end
endmodule : io_segment_translation_tb
